// ---- logic/cmd_pkg.sv ----
// cmd_pkg: constants and types shared by the mode decoder and cycle sequencer.
// assumes one 16-bit address space with a byte-wide data path.

package cmd_pkg;

  // opcodes handled here
  localparam logic [7:0] OP_PRE       = 8'h9E;
  localparam logic [7:0] OP_XFER_SP   = 8'h94;
  localparam logic [7:0] OP_WAIT      = 8'h8F;
  localparam logic [7:0] OP_BRA       = 8'h20;
  localparam logic [7:0] OP_LDHX      = 8'h45;
  localparam logic [7:0] OP_PULA      = 8'h86;
  localparam logic [7:0] OP_PSHA      = 8'h87;
  localparam logic [7:0] OP_CBEQ_IXP  = 8'h71;
  localparam logic [7:0] OP_CBEQ_IX1P = 8'h61;
  localparam logic [3:0] OP_BIT_HI    = 4'h1;
  localparam logic [3:0] OP_LDA_LO    = 4'h6;

  // high nibble of the load family selects the addressing mode
  localparam logic [3:0] MODE_LIT   = 4'hA;
  localparam logic [3:0] MODE_DIR   = 4'hB;
  localparam logic [3:0] MODE_ABS   = 4'hC;
  localparam logic [3:0] MODE_IDX16 = 4'hD;
  localparam logic [3:0] MODE_IX  = 4'hF;

  // flag positions and reset values
  localparam int          FLG_I = 3;
  localparam int          FLG_N = 2;
  localparam int          FLG_Z = 1;
  localparam logic [7:0]  FLG_RST   = 8'h68;
  localparam logic [15:0] SP_RST    = 16'h00FF;
  localparam logic [7:0]  ZERO_PAGE = 8'h00;
  localparam logic [7:0]  VEC_PAGE  = 8'hFF;
  localparam logic [2:0]  PUSH_LAST = 3'h4;

  typedef enum logic [3:0] {
    S_VEC_H, S_VEC_L, S_OPC, S_OPA1, S_OPA2, S_RD, S_WR, S_FREE,
    S_REL, S_PUSH, S_POP, S_WAITP, S_HALT
  } cmd_state_t;

  typedef enum logic [3:0] {
    K_NOP, K_XSP, K_WAIT, K_BRA, K_LDHX, K_LDA, K_BIT, K_CBEQ, K_PUL, K_PSH, K_EXC
  } cmd_kind_t;

  typedef struct packed {
    cmd_state_t  st;
    cmd_kind_t   kind;
    logic [7:0]  op;
    logic        pre;
    logic        pre_pend;
    logic        hit;
    logic [2:0]  cnt;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] hx;
    logic [7:0]  a;
    logic [7:0]  flg;
    logic [7:0]  tmp;
    logic [15:0] ea;
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
    logic        halt;
  } cmd_regs_t;

endpackage

// ---- logic/cmd_seq.sv ----
// cmd_seq: addressing-mode decode and bus-cycle sequencing for a byte cpu core.
// assumes memory answers bus_rdata in the same cycle as bus_addr is shown.
`timescale 1ns/1ps
`default_nettype none

module cmd_seq #(
  parameter logic [15:0] RST_VEC_ADDR = 16'hFFFE,
  parameter logic [15:0] IRQ_VEC_ADDR = 16'hFFFA
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // memory bus
  output logic [15:0] bus_addr,
  output logic        bus_rd,
  output logic        bus_wr,
  output logic [7:0]  bus_wdata,
  input  wire logic [7:0]  bus_rdata,
  // interrupt and status
  input  wire logic        irq_req,
  output logic        cpu_halted
);

  // vectors are read as a pair from the top page
  if (RST_VEC_ADDR[15:8] != cmd_pkg::VEC_PAGE || RST_VEC_ADDR[0] ||
      IRQ_VEC_ADDR[15:8] != cmd_pkg::VEC_PAGE || IRQ_VEC_ADDR[0]) begin : g_chk
    $error("vector addresses must be even and in the top page");
  end

  localparam cmd_pkg::cmd_regs_t RST = '{
    st: cmd_pkg::S_VEC_H, kind: cmd_pkg::K_NOP, op: 8'h00, pre: 1'b0,
    pre_pend: 1'b0, hit: 1'b0, cnt: 3'h0, pc: 16'h0000, sp: cmd_pkg::SP_RST,
    hx: 16'h0000, a: 8'h00, flg: cmd_pkg::FLG_RST, tmp: 8'h00, ea: RST_VEC_ADDR,
    addr: RST_VEC_ADDR, rd: 1'b1, wr: 1'b0, wdata: 8'h00, halt: 1'b0};

  cmd_pkg::cmd_regs_t q;
  cmd_pkg::cmd_regs_t d;
  logic [15:0]        base;

  // one state per bus cycle; bus outputs for the next cycle are formed here
  always_comb begin
    d    = q;
    base = q.pre ? q.sp : q.hx;
    case (q.st)
      cmd_pkg::S_VEC_H: begin
        d.tmp = bus_rdata;
        d.st  = cmd_pkg::S_VEC_L;
      end
      cmd_pkg::S_VEC_L: begin
        d.pc = {q.tmp, bus_rdata};
        d.st = cmd_pkg::S_OPC;
      end
      cmd_pkg::S_OPC: begin
        d.pc       = q.pc + 16'h0001;
        d.op       = bus_rdata;
        d.pre      = q.pre_pend;
        d.pre_pend = 1'b0;
        d.kind     = cmd_pkg::K_NOP;
        d.st       = cmd_pkg::S_OPC;
        if (bus_rdata == cmd_pkg::OP_PRE && !q.pre_pend) begin
          d.pre_pend = 1'b1;
        end else if (bus_rdata == cmd_pkg::OP_XFER_SP) begin
          d.kind = cmd_pkg::K_XSP;
          d.st   = cmd_pkg::S_FREE;
        end else if (bus_rdata == cmd_pkg::OP_WAIT) begin
          d.kind = cmd_pkg::K_WAIT;
          d.st   = cmd_pkg::S_FREE;
        end else if (bus_rdata == cmd_pkg::OP_BRA) begin
          d.kind = cmd_pkg::K_BRA;
          d.st   = cmd_pkg::S_REL;
        end else if (bus_rdata == cmd_pkg::OP_LDHX) begin
          d.kind = cmd_pkg::K_LDHX;
          d.st   = cmd_pkg::S_OPA1;
        end else if (bus_rdata == cmd_pkg::OP_PULA) begin
          d.kind = cmd_pkg::K_PUL;
          d.st   = cmd_pkg::S_FREE;
        end else if (bus_rdata == cmd_pkg::OP_PSHA) begin
          d.kind = cmd_pkg::K_PSH;
          d.st   = cmd_pkg::S_PUSH;
        end else if (bus_rdata == cmd_pkg::OP_CBEQ_IXP) begin
          d.kind = cmd_pkg::K_CBEQ;
          d.ea   = q.hx;
          d.st   = cmd_pkg::S_RD;
        end else if (bus_rdata == cmd_pkg::OP_CBEQ_IX1P) begin
          d.kind = cmd_pkg::K_CBEQ;
          d.st   = cmd_pkg::S_OPA1;
        end else if (bus_rdata[7:4] == cmd_pkg::OP_BIT_HI) begin
          d.kind = cmd_pkg::K_BIT;
          d.cnt  = bus_rdata[3:1];
          d.st   = cmd_pkg::S_OPA1;
        end else if (bus_rdata[3:0] == cmd_pkg::OP_LDA_LO &&
                     bus_rdata[7:4] >= cmd_pkg::MODE_LIT) begin
          d.kind = cmd_pkg::K_LDA;
          if (bus_rdata[7:4] == cmd_pkg::MODE_IX && !q.pre_pend) begin
            d.ea = q.hx;
            d.st = cmd_pkg::S_RD;
          end else begin
            d.st = cmd_pkg::S_OPA1;
          end
        end
      end
      cmd_pkg::S_OPA1: begin
        d.pc  = q.pc + 16'h0001;
        d.tmp = bus_rdata;
        d.st  = cmd_pkg::S_RD;
        case (q.kind)
          cmd_pkg::K_LDHX: d.st = cmd_pkg::S_OPA2;
          cmd_pkg::K_BIT:  d.ea = {cmd_pkg::ZERO_PAGE, bus_rdata};
          cmd_pkg::K_CBEQ: d.ea = q.hx + {8'h00, bus_rdata};
          cmd_pkg::K_LDA: begin
            case (q.op[7:4])
              cmd_pkg::MODE_LIT: begin
                d.a          = bus_rdata;
                d.flg[cmd_pkg::FLG_N] = bus_rdata[7];
                d.flg[cmd_pkg::FLG_Z] = (bus_rdata == 8'h00);
                d.st         = cmd_pkg::S_OPC;
              end
              cmd_pkg::MODE_DIR: d.ea = {cmd_pkg::ZERO_PAGE, bus_rdata};
              cmd_pkg::MODE_ABS, cmd_pkg::MODE_IDX16: d.st = cmd_pkg::S_OPA2;
              default: d.ea = base + {8'h00, bus_rdata};
            endcase
          end
          default: d.st = cmd_pkg::S_OPC;
        endcase
      end
      cmd_pkg::S_OPA2: begin
        d.pc = q.pc + 16'h0001;
        d.st = cmd_pkg::S_RD;
        if (q.kind == cmd_pkg::K_LDHX) begin
          d.hx = {q.tmp, bus_rdata};
          d.st = cmd_pkg::S_OPC;
        end else if (q.op[7:4] == cmd_pkg::MODE_ABS) begin
          d.ea = {q.tmp, bus_rdata};
        end else begin
          d.ea = base + {q.tmp, bus_rdata};
        end
      end
      cmd_pkg::S_RD: begin
        d.st = cmd_pkg::S_OPC;
        case (q.kind)
          cmd_pkg::K_LDA: begin
            d.a          = bus_rdata;
            d.flg[cmd_pkg::FLG_N] = bus_rdata[7];
            d.flg[cmd_pkg::FLG_Z] = (bus_rdata == 8'h00);
          end
          cmd_pkg::K_BIT: begin
            d.tmp        = bus_rdata;
            d.tmp[q.cnt] = !q.op[0];
            d.st         = cmd_pkg::S_FREE;
          end
          cmd_pkg::K_CBEQ: begin
            d.hit = (bus_rdata == q.a);
            d.hx  = q.hx + 16'h0001;
            d.st  = cmd_pkg::S_REL;
          end
          default: d.st = cmd_pkg::S_OPC;
        endcase
      end
      cmd_pkg::S_REL: begin
        // next instruction starts right after the displacement byte
        d.pc = q.pc + 16'h0001;
        if (q.kind == cmd_pkg::K_BRA || q.hit) begin
          d.pc = q.pc + 16'h0001 + {{8{bus_rdata[7]}}, bus_rdata};
        end
        d.st = cmd_pkg::S_OPC;
      end
      cmd_pkg::S_FREE: begin
        d.st = cmd_pkg::S_OPC;
        case (q.kind)
          cmd_pkg::K_XSP:  d.sp = q.hx - 16'h0001;
          cmd_pkg::K_WAIT: begin
            d.flg[cmd_pkg::FLG_I] = 1'b0;
            d.st = cmd_pkg::S_WAITP;
          end
          cmd_pkg::K_BIT:  d.st = cmd_pkg::S_WR;
          cmd_pkg::K_PUL: begin
            d.ea = q.sp + 16'h0001;
            d.st = cmd_pkg::S_POP;
          end
          default: d.st = cmd_pkg::S_OPC;
        endcase
      end
      cmd_pkg::S_WR: d.st = cmd_pkg::S_OPC;
      cmd_pkg::S_POP: begin
        d.a  = bus_rdata;
        d.sp = q.ea;
        d.st = cmd_pkg::S_OPC;
      end
      cmd_pkg::S_PUSH: begin
        d.sp = q.sp - 16'h0001;
        d.st = cmd_pkg::S_OPC;
        if (q.kind == cmd_pkg::K_EXC) begin
          d.cnt = q.cnt + 3'h1;
          d.st  = cmd_pkg::S_PUSH;
          if (q.cnt == cmd_pkg::PUSH_LAST) begin
            d.ea  = IRQ_VEC_ADDR;
            d.flg[cmd_pkg::FLG_I] = 1'b1;
            d.st  = cmd_pkg::S_VEC_H;
          end
        end
      end
      cmd_pkg::S_WAITP: begin
        d.pc = q.pc + 16'h0001;
        d.st = cmd_pkg::S_HALT;
      end
      cmd_pkg::S_HALT: begin
        // the prefetched byte is dropped, so return to pc minus one
        if (irq_req && !q.flg[cmd_pkg::FLG_I]) begin
          d.kind = cmd_pkg::K_EXC;
          d.cnt  = 3'h0;
          d.ea   = q.pc - 16'h0001;
          d.st   = cmd_pkg::S_PUSH;
        end
      end
      default: begin
        d.ea = RST_VEC_ADDR;
        d.st = cmd_pkg::S_VEC_H;
      end
    endcase

    // bus view of the coming cycle, free cycles show as reads of pc
    d.rd    = 1'b1;
    d.wr    = 1'b0;
    d.addr  = d.pc;
    d.wdata = 8'h00;
    case (d.st)
      cmd_pkg::S_RD, cmd_pkg::S_POP, cmd_pkg::S_VEC_H: d.addr = d.ea;
      cmd_pkg::S_VEC_L: d.addr = d.ea + 16'h0001;
      cmd_pkg::S_WR: begin
        d.addr  = d.ea;
        d.rd    = 1'b0;
        d.wr    = 1'b1;
        d.wdata = d.tmp;
      end
      cmd_pkg::S_PUSH: begin
        d.addr = d.sp;
        d.rd   = 1'b0;
        d.wr   = 1'b1;
        if (d.kind == cmd_pkg::K_PSH) begin
          d.wdata = d.a;
        end else begin
          case (d.cnt)
            3'h0:    d.wdata = d.ea[7:0];
            3'h1:    d.wdata = d.ea[15:8];
            3'h2:    d.wdata = d.hx[7:0];
            3'h3:    d.wdata = d.a;
            default: d.wdata = d.flg;
          endcase
        end
      end
      cmd_pkg::S_HALT: d.rd = 1'b0;
      default: d.rd = 1'b1;
    endcase
    d.halt = (d.st == cmd_pkg::S_HALT);
  end

  // state register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign bus_addr   = q.addr;
  assign bus_rd     = q.rd;
  assign bus_wr     = q.wr;
  assign bus_wdata  = q.wdata;
  assign cpu_halted = q.halt;

  // checks on the sequencer
  property p_xsp;
    @(posedge core_clk) disable iff (!arst_n)
    (q.st == cmd_pkg::S_OPC && bus_rdata == cmd_pkg::OP_XFER_SP && !q.pre_pend) |=>
      (q.st == cmd_pkg::S_FREE) ##1
      (q.st == cmd_pkg::S_OPC && q.sp == q.hx - 16'h0001 && q.flg == $past(q.flg, 2));
  endproperty
  a_xsp: assert property (p_xsp) else $error("index copy sequence wrong");

  property p_wait;
    @(posedge core_clk) disable iff (!arst_n)
    (q.st == cmd_pkg::S_OPC && bus_rdata == cmd_pkg::OP_WAIT && !q.pre_pend) |=>
      q.st == cmd_pkg::S_FREE ##1 q.st == cmd_pkg::S_WAITP ##1
      (q.st == cmd_pkg::S_HALT && !q.flg[cmd_pkg::FLG_I] && cpu_halted);
  endproperty
  a_wait: assert property (p_wait) else $error("wait sequence wrong");

  property p_free;
    @(posedge core_clk) disable iff (!arst_n)
    (q.st == cmd_pkg::S_FREE) |-> (bus_rd && !bus_wr) ##1 (q.st != cmd_pkg::S_FREE);
  endproperty
  a_free: assert property (p_free) else $error("free cycle wrong");

  property p_fetch;
    @(posedge core_clk) disable iff (!arst_n)
    (q.st == cmd_pkg::S_OPC) |-> (bus_addr == q.pc && bus_rd) ##1
      (q.pc == $past(q.pc) + 16'h0001);
  endproperty
  a_fetch: assert property (p_fetch) else $error("program fetch wrong");

  property p_vec;
    @(posedge core_clk) disable iff (!arst_n)
    (q.st == cmd_pkg::S_VEC_H) |-> (bus_addr[15:8] == cmd_pkg::VEC_PAGE) ##1
      (q.st == cmd_pkg::S_VEC_L && bus_addr == $past(bus_addr) + 16'h0001) ##1
      (q.pc == {$past(bus_rdata, 2), $past(bus_rdata)});
  endproperty
  a_vec: assert property (p_vec) else $error("vector fetch wrong");

  property p_push;
    @(posedge core_clk) disable iff (!arst_n)
    (q.st == cmd_pkg::S_PUSH) |-> (bus_wr && !bus_rd && bus_addr == q.sp) ##1
      (q.sp == $past(q.sp) - 16'h0001);
  endproperty
  a_push: assert property (p_push) else $error("stack push wrong");

  property p_rel;
    @(posedge core_clk) disable iff (!arst_n)
    (q.st == cmd_pkg::S_REL && q.kind == cmd_pkg::K_BRA) |=>
      q.pc == $past(q.pc) + 16'h0001 + {{8{$past(bus_rdata[7])}}, $past(bus_rdata)};
  endproperty
  a_rel: assert property (p_rel) else $error("branch target wrong");

  property p_dir;
    @(posedge core_clk) disable iff (!arst_n)
    (q.st == cmd_pkg::S_OPA1 && q.kind == cmd_pkg::K_BIT) |=>
      (q.st == cmd_pkg::S_RD && bus_addr == {cmd_pkg::ZERO_PAGE, $past(bus_rdata)});
  endproperty
  a_dir: assert property (p_dir) else $error("page zero address wrong");

  property p_idx8;
    @(posedge core_clk) disable iff (!arst_n)
    (q.st == cmd_pkg::S_OPA1 && q.kind == cmd_pkg::K_LDA && !q.pre &&
     q.op == {4'hE, cmd_pkg::OP_LDA_LO}) |=>
      bus_addr == q.hx + {8'h00, $past(bus_rdata)};
  endproperty
  a_idx8: assert property (p_idx8) else $error("indexed offset wrong");

  property p_halt;
    @(posedge core_clk) disable iff (!arst_n)
    (q.st == cmd_pkg::S_HALT && !(irq_req && !q.flg[cmd_pkg::FLG_I])) |=>
      (q.st == cmd_pkg::S_HALT && !bus_rd && !bus_wr);
  endproperty
  a_halt: assert property (p_halt) else $error("left halt without cause");

  c_wake: cover property (@(posedge core_clk) disable iff (!arst_n)
    q.st == cmd_pkg::S_HALT ##1 q.st == cmd_pkg::S_PUSH);
  c_bset: cover property (@(posedge core_clk) disable iff (!arst_n)
    q.st == cmd_pkg::S_WR);
  c_cbeq: cover property (@(posedge core_clk) disable iff (!arst_n)
    q.st == cmd_pkg::S_REL && q.kind == cmd_pkg::K_CBEQ && q.hit);

endmodule // cmd_seq

`default_nettype wire

// ---- bench/cmd_mem_model.sv ----
// cmd_mem_model: byte memory on the core bus, answering reads in the same cycle.
// assumes the bench loads its contents through mem before the core reads them.
`timescale 1ns/1ps
`default_nettype none

module cmd_mem_model (
  // clock
  input  wire logic        core_clk,
  // core bus
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic [7:0]  bus_wdata,
  output logic [7:0]       bus_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;

  // off-bus cycles show inverted stale data, so a lucky settle never passes
  assign bus_rdata = bus_rd ? mem[bus_addr] : ~last_q;

  // writes land at the edge that ends the cycle
  always @(posedge core_clk) begin
    if (bus_wr) mem[bus_addr] <= bus_wdata;
    if (bus_rd) last_q <= mem[bus_addr];
  end
endmodule // cmd_mem_model

`default_nettype wire

// ---- bench/cpu_mode_decode_and_cycle_sequencing_test.sv ----
// cpu_mode_decode_and_cycle_sequencing_test: random instruction stream walked cycle by cycle.
// assumes cmd_pkg, cmd_seq and cmd_mem_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module cpu_mode_decode_and_cycle_sequencing_test;
  // core and memory wiring
  logic        core_clk;
  logic        arst_n;
  logic        irq_req;
  logic [15:0] bus_addr;
  logic        bus_rd;
  logic        bus_wr;
  logic [7:0]  bus_wdata;
  logic [7:0]  bus_rdata;
  logic        cpu_halted;
  // bookkeeping and a model of the core registers
  int          mismatches;
  int          tests_run;
  int          seed;
  logic [15:0] pc, hx, sp, r;
  logic [7:0]  a;
  // load family tables: high nibble and operand count per mode
  localparam logic [31:0] LOP = 32'hDEFEDCBA;
  localparam logic [15:0] LEN = 16'h91A5;

  cmd_seq dut_u (.core_clk(core_clk), .arst_n(arst_n), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .irq_req(irq_req), .cpu_halted(cpu_halted));
  cmd_mem_model mem_u (.core_clk(core_clk), .bus_addr(bus_addr), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

  // 50 ns core clock
  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  function automatic logic [15:0] rn();
    return 16'($random(seed));
  endfunction

  function automatic logic [15:0] sx(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction

  // one bus cycle; k: 0 read, 1 free (any address), 2 write, 3 write with data unchecked
  task automatic cyc(input logic [15:0] ad, input logic [1:0] k, input logic [7:0] wd);
    if (k != 2'h1) `CHK("addr", ad, bus_addr)
    `CHK("rd", !k[1], bus_rd)
    `CHK("wr", k[1], bus_wr)
    if (k == 2'h2) `CHK("wdata", wd, bus_wdata)
    @(posedge core_clk);
    irq_req <= 1'b0;
    #1;
  endtask

  task automatic fetch(input int n);
    for (int i = 0; i < n; i++) cyc(pc + 16'(i), 2'h0, 8'h00);
  endtask

  // instruction bytes at pc; data is always read back after this, so overlaps stay consistent
  task automatic lay(input logic [7:0] b0, b1, b2, b3);
    mem_u.mem[pc] = b0;
    mem_u.mem[pc + 16'h1] = b1;
    mem_u.mem[pc + 16'h2] = b2;
    mem_u.mem[pc + 16'h3] = b3;
  endtask

  // one instruction: lay it, walk its cycles, advance the register model
  task automatic step(input int k, input logic [16:0] pick);
    logic [15:0] v, ea;
    logic [7:0]  o, d;
    int          n, m;
    v = pick[16] ? pick[15:0] : rn();
    n = $random(seed) & 15;
    case (k)
      0: begin // index pair kept in the upper half, clear of the program
        v[15:14] = 2'b10;
        lay(cmd_pkg::OP_LDHX, v[15:8], v[7:0], 8'h00);
        fetch(3);
        hx = v;
        pc += 16'h3;
      end
      1: begin
        lay(cmd_pkg::OP_XFER_SP, 8'h00, 8'h00, 8'h00);
        cyc(pc, 2'h0, 8'h00);
        cyc(pc + 16'h1, 2'h0, 8'h00);
        sp = hx - 16'h1;
        pc += 16'h1;
      end
      2: begin // load family in every addressing mode
        n = n & 7;
        m = LEN[n*2 +: 2];
        o = {LOP[n*4 +: 4], 4'h6};
        ea = (n >= 6) ? sp : (n >= 3) ? hx : 16'h0000;
        ea += (m == 2) ? v : (m == 1) ? {8'h00, v[15:8]} : 16'h0000;
        if (n >= 6) lay(8'h9E, o, v[15:8], v[7:0]);
        else lay(o, v[15:8], v[7:0], 8'h00);
        m += 1 + int'(n >= 6);
        fetch(m);
        a = (n == 0) ? v[15:8] : mem_u.mem[ea];
        if (n != 0) cyc(ea, 2'h0, 8'h00);
        pc += 16'(m);
      end
      3: begin
        lay(cmd_pkg::OP_PSHA, 8'h00, 8'h00, 8'h00);
        fetch(1);
        cyc(sp, 2'h2, a);
        sp -= 16'h1;
        pc += 16'h1;
      end
      4: begin
        lay(cmd_pkg::OP_PULA, 8'h00, 8'h00, 8'h00);
        fetch(1);
        cyc(pc, 2'h1, 8'h00);
        sp += 16'h1;
        a = mem_u.mem[sp];
        cyc(sp, 2'h0, 8'h00);
        pc += 16'h1;
      end
      5: begin // page-zero bit set or clear, all sixteen opcodes
        ea = {8'h00, v[7:0]};
        lay(8'h10 + 8'(n), v[7:0], 8'h00, 8'h00);
        d = mem_u.mem[ea];
        d = n[0] ? d & ~(8'h01 << (n >> 1)) : d | (8'h01 << (n >> 1));
        fetch(2);
        cyc(ea, 2'h0, 8'h00);
        cyc(ea, 2'h1, 8'h00);
        cyc(ea, 2'h2, d);
        pc += 16'h2;
      end
      6: begin
        lay(cmd_pkg::OP_BRA, v[7:0], 8'h00, 8'h00);
        fetch(2);
        pc += 16'h2 + sx(v[7:0]);
      end
      default: begin // compare and branch, index stepped after the read
        n = n & 1;
        ea = hx + (n ? {8'h00, v[15:8]} : 16'h0000);
        mem_u.mem[ea] = v[1] ? a : ~a;
        lay(n ? cmd_pkg::OP_CBEQ_IX1P : cmd_pkg::OP_CBEQ_IXP, v[15:8], v[7:0], 8'h00);
        d = n ? v[7:0] : v[15:8];
        o = mem_u.mem[ea];
        cyc(pc, 2'h0, 8'h00);
        if (n) cyc(pc + 16'h1, 2'h0, 8'h00);
        cyc(ea, 2'h0, 8'h00);
        cyc(pc + 16'h1 + 16'(n), 2'h0, 8'h00);
        hx += 16'h1;
        pc += 16'h2 + 16'(n) + ((o == a) ? sx(d) : 16'h0000);
      end
    endcase
  endtask

  // wait opcode, idle while halted, then wake through the interrupt sequence
  task automatic wait_wake();
    logic [15:0] vec;
    int          t;
    vec = rn();
    vec[15:14] = 2'b01;
    mem_u.mem[16'hFFFA] = vec[15:8];
    mem_u.mem[16'hFFFB] = vec[7:0];
    lay(cmd_pkg::OP_WAIT, 8'h00, 8'h00, 8'h00);
    fetch(1);
    cyc(pc + 16'h1, 2'h0, 8'h00);
    cyc(pc + 16'h1, 2'h0, 8'h00);
    for (t = 0; t < 6; t++) begin
      `CHK("halted", 1'b1, cpu_halted)
      `CHK("rd", 1'b0, bus_rd)
      @(posedge core_clk);
      irq_req <= (t == 5);
      #1;
    end
    for (t = 0; t < 4 && bus_wr !== 1'b1; t++) begin
      @(posedge core_clk);
      #1;
    end
    r = pc + 16'h1;
    cyc(sp, 2'h2, r[7:0]);
    cyc(sp - 16'h1, 2'h2, r[15:8]);
    cyc(sp - 16'h2, 2'h2, hx[7:0]);
    cyc(sp - 16'h3, 2'h2, a);
    `CHK("mask", 1'b0, bus_wdata[cmd_pkg::FLG_I])
    cyc(sp - 16'h4, 2'h3, 8'h00);
    sp -= 16'h5;
    cyc(16'hFFFA, 2'h0, 8'h00);
    cyc(16'hFFFB, 2'h0, 8'h00);
    `CHK("halted", 1'b0, cpu_halted)
    pc = vec;
  endtask

  task automatic close_out();
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // main sequence: reset, hand corners, random stream, wait and wake, more stream
  initial begin
    seed = 1;
    mismatches = 0;
    tests_run = 0;
    arst_n = 1'b0;
    irq_req = 1'b0;
    for (int i = 0; i < 65536; i++) mem_u.mem[i] = 8'(rn());
    r = rn();
    pc = {8'h40, r[7:0]};
    mem_u.mem[16'hFFFE] = pc[15:8];
    mem_u.mem[16'hFFFF] = pc[7:0];
    hx = 16'h0000;
    sp = cmd_pkg::SP_RST;
    a = 8'h00;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    #1;
    cyc(16'hFFFE, 2'h0, 8'h00);
    cyc(16'hFFFF, 2'h0, 8'h00);
    step(0, 17'h18000);
    step(1, 17'h0);
    step(3, 17'h0);
    step(4, 17'h0);
    step(6, 17'h10080);
    step(6, 17'h1007F);
    repeat (150) step($random(seed) & 7, 17'h0);
    wait_wake();
    repeat (150) step($random(seed) & 7, 17'h0);
    close_out();
  end

  // watchdog, far beyond the roughly 1000 cycles the run needs
  initial begin
    #500000;
    mismatches++;
    close_out();
  end
endmodule // cpu_mode_decode_and_cycle_sequencing_test

`default_nettype wire
